// ---- rtl/scm_defines.vh ----
// Purpose: shared constants for the serial command-mode configuration block
// Assumes: 250 MHz system clock
// Notes: times in 100 ms units are converted to cycles by scm_tick
`ifndef SCM_DEFINES_VH
`define SCM_DEFINES_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define SCM_CLOCK_MHZ 250
`define SCM_GUARD_UNIT_MS 100
`define SCM_GUARD_UNIT_CYCLES (`SCM_GUARD_UNIT_MS * 1000 * `SCM_CLOCK_MHZ)

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define SCM_GUARD_BEFORE_RST 16'h000A
`define SCM_GUARD_AFTER_RST 16'h000A
`define SCM_GUARD_AFTER_MIN 16'h0002
`define SCM_GUARD_AFTER_MAX 16'h7FFC
`define SCM_SLEEP_MARGIN 16'h0003
`define SCM_ESCAPE_RST 8'h2B
`define SCM_ESCAPE_MIN 8'h20
`define SCM_ESCAPE_MAX 8'h7F
`define SCM_UART_RATE_RST 4'h3
`define SCM_UART_RATE_MAX 4'h8
`define SCM_AIR_RATE_RST 1'b1
`define SCM_OUT2_RST 2'h2
`define SCM_OUT2_MAX 2'h2
`define SCM_OUT1_RST 3'h0
`define SCM_OUT1_MAX 3'h4
`define SCM_FORMAT_RST 2'h1
`define SCM_FORMAT_MAX 2'h2
`define SCM_ESCAPE_COUNT 2'h3

// ----------------------------------------
// binary command codes
// ----------------------------------------
`define SCM_CMD_GUARD_BEFORE 8'h04
`define SCM_CMD_GUARD_AFTER 8'h05
`define SCM_CMD_LEAVE 8'h09
`define SCM_CMD_ESCAPE 8'h13
`define SCM_CMD_UART_RATE 8'h15
`define SCM_CMD_OUT2 8'h28
`define SCM_CMD_FORMAT 8'h1F
`define SCM_CMD_OUT1 8'h2C
`define SCM_CMD_LAST_RSSI 8'h36
`define SCM_CMD_AIR_RATE 8'h39
`define SCM_CMD_VOLTAGE 8'h3B
`define SCM_CMD_AUTO_ADDR 8'h40
`define SCM_CMD_FW_VERSION 8'h14
`define SCM_CMD_HW_VERSION 8'h16

// ----------------------------------------
// output and number format codes
// ----------------------------------------
`define SCM_OUT2_RX_LED 2'h0
`define SCM_OUT2_HIGH 2'h1
`define SCM_OUT2_LOW 2'h2
`define SCM_OUT1_CTS 3'h0
`define SCM_OUT1_TXEN_LOW 3'h1
`define SCM_OUT1_HIGH 3'h2
`define SCM_OUT1_TXEN_HIGH 3'h3
`define SCM_OUT1_LOW 3'h4
`define SCM_FMT_NATIVE_UNITS 2'h0
`define SCM_FMT_HEX 2'h1
`define SCM_FMT_NATIVE 2'h2

`endif

// ---- rtl/scm_tick.v ----
// Purpose: 100 ms time-base prescaler
// Assumes: clear restarts the count
// Notes: one-cycle tick every UNIT_CYCLES clocks
`timescale 1ns/1ns
`include "scm_defines.vh"

module scm_tick #(
	parameter [31:0] UNIT_CYCLES = `SCM_GUARD_UNIT_CYCLES
) (
	// clock and reset
	input wire clock,
	input wire arst_n,
	// control
	input wire clear,
	output reg tick
);

reg [31:0] count;

always @(posedge clock or negedge arst_n) begin
	if (!arst_n) begin
		count <= 32'h0000_0000;
		tick <= 1'b0;
	end else if (clear) begin
		count <= 32'h0000_0000;
		tick <= 1'b0;
	end else if (count >= UNIT_CYCLES - 32'h0000_0001) begin
		count <= 32'h0000_0000;
		tick <= 1'b1;
	end else begin
		count <= count + 32'h0000_0001;
		tick <= 1'b0;
	end
end

endmodule // scm_tick

// ---- rtl/scm_sync.v ----
// Purpose: two-flop synchroniser for a pin level
// Assumes: input is asynchronous to clock
// Notes: first stage feeds only the second
`timescale 1ns/1ns

module scm_sync (
	// clock and reset
	input wire clock,
	input wire arst_n,
	// data
	input wire async_in,
	output reg sync_out
);

reg stage;

always @(posedge clock or negedge arst_n) begin
	if (!arst_n) begin
		stage <= 1'b0;
		sync_out <= 1'b0;
	end else begin
		stage <= async_in;
		sync_out <= stage;
	end
end

endmodule // scm_sync

// ---- rtl/scm_command_mode.v ----
// Purpose: serial command-mode entry detector and configuration holder
// Assumes: received characters arrive as a same-clock byte strobe
// Notes: replies are binary; one or two bytes leave on a byte strobe
//
// Functional notes
// RULE1: command mode entered only after silence, three escape chars, silence.
// RULE2: guard-before accepts 0..FFFF in 100 ms units, resets to 0x0A.
// RULE3: guard-after accepts 2..(sleep time minus 3), max 0x7FFC, default 0x0A.
// RULE4: escape character programmable 0x20..0x7F, default plus sign 0x2B.
// RULE5: uart rate codes 0..8 select 1200..230400 bps; default code 3.
// RULE6: new uart rate takes effect only on leaving command mode.
// RULE7: air rate code 0 or 1, default 1, independent of uart rate.
// RULE8: output two: 0 receive LED, 1 high, 2 low; default 2.
// RULE9: output one: 0 CTS, 1 low tx enable, 3 high tx enable, 2/4 fixed.
// RULE10: number format 0..2: native with units, forced hex, native; default 1.
// RULE11: firmware, hardware version and key values always hexadecimal.
// RULE12: default format treats numeric parameters from host as hexadecimal.
// RULE13: leave command 0x09 exits command mode immediately.
// RULE14: auto address takes serial bits 29, 28, 13..0 and reports it.
// RULE15: hex voltage readout is volts times 65536, range 0x2CCCA..0x5BFFA.
// RULE16: signal strength 0x6E..0x28 magnitude, formatted per number format.
// RULE17: binary codes 0x04, 0x05, 0x13 select guard times and escape char.
// RULE18: uart rate read returns one byte, guard times return two.
// RULE19: character during silence or non-escape among three aborts entry.
`timescale 1ns/1ns
`include "scm_defines.vh"

module scm_command_mode #(
	parameter [31:0] UNIT_CYCLES = `SCM_GUARD_UNIT_CYCLES
) (
	// clock and reset
	input wire clock,
	input wire arst_n,
	// received serial characters
	input wire rx_valid,
	input wire [7:0] rx_data,
	// host command port, used while in command mode
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	input wire cmd_write,
	input wire [15:0] cmd_value,
	// device status inputs
	input wire [31:0] serial_number,
	input wire [15:0] sleep_inactivity_time,
	input wire [18:0] board_voltage,
	input wire [6:0] last_packet_rssi,
	input wire [15:0] firmware_version,
	input wire [15:0] hardware_version,
	input wire cts_level,
	input wire tx_active,
	input wire rx_activity_pin,
	// mode and data path
	output reg command_mode,
	output reg data_valid,
	output reg [7:0] data_byte,
	// active settings
	output reg [3:0] active_uart_rate,
	output reg [17:0] uart_bps,
	output reg air_rate_select,
	output reg [1:0] number_format,
	output reg [15:0] source_address,
	// general outputs
	output reg general_out_one,
	output reg general_out_two,
	// replies
	output reg reply_valid,
	output reg [7:0] reply_byte,
	output reg reply_hex,
	output reg reply_units,
	output reg [18:0] reply_value,
	output reg cmd_error
);

// ----------------------------------------
// state
// ----------------------------------------
localparam [4:0] ST_IDLE = 5'b00001;
localparam [4:0] ST_ESC = 5'b00010;
localparam [4:0] ST_AFTER = 5'b00100;
localparam [4:0] ST_CMD = 5'b01000;
localparam [4:0] ST_REPLY = 5'b10000;

reg [4:0] state;
reg [15:0] guard_before_time;
reg [15:0] guard_after_time;
reg [7:0] escape_char_code;
reg [3:0] uart_rate_select;
reg [1:0] out2_function;
reg [2:0] out1_function;
reg [15:0] silence;
reg [1:0] esc_count;
reg [7:0] held_low;
reg [1:0] held_count;
reg reply_second;
reg [7:0] reply_low;
reg [3:0] next_rate;

wire tick;
wire rx_led;
wire [15:0] auto_addr;
wire [15:0] after_limit;

// silence counter restarts on every character
scm_tick #(
	.UNIT_CYCLES(UNIT_CYCLES)
) u_tick (
	.clock(clock),
	.arst_n(arst_n),
	.clear(rx_valid),
	.tick(tick)
);

// the led pin is external, so it is synchronised before use
scm_sync u_led_sync (
	.clock(clock),
	.arst_n(arst_n),
	.async_in(rx_activity_pin),
	.sync_out(rx_led)
);

assign auto_addr = {serial_number[29], serial_number[28], serial_number[13:0]}; // see RULE14
assign after_limit = (sleep_inactivity_time - `SCM_SLEEP_MARGIN > `SCM_GUARD_AFTER_MAX) ?
	`SCM_GUARD_AFTER_MAX : sleep_inactivity_time - `SCM_SLEEP_MARGIN;

// rate table lookup
always @* begin
	next_rate = uart_rate_select;
	case (active_uart_rate)
		4'h0: uart_bps = 18'd1200; // see RULE5
		4'h1: uart_bps = 18'd2400;
		4'h2: uart_bps = 18'd4800;
		4'h3: uart_bps = 18'd9600;
		4'h4: uart_bps = 18'd19200;
		4'h5: uart_bps = 18'd38400;
		4'h6: uart_bps = 18'd57600;
		4'h7: uart_bps = 18'd115200;
		default: uart_bps = 18'd230400;
	endcase
end

// ----------------------------------------
// entry sequence and command handling
// ----------------------------------------
always @(posedge clock or negedge arst_n) begin
	if (!arst_n) begin
		state <= ST_IDLE;
		silence <= 16'h0000;
		esc_count <= 2'h0;
		held_low <= 8'h00;
		held_count <= 2'h0;
		command_mode <= 1'b0;
		data_valid <= 1'b0;
		data_byte <= 8'h00;
		guard_before_time <= `SCM_GUARD_BEFORE_RST; // see RULE2
		guard_after_time <= `SCM_GUARD_AFTER_RST; // see RULE3
		escape_char_code <= `SCM_ESCAPE_RST; // see RULE4
		uart_rate_select <= `SCM_UART_RATE_RST;
		active_uart_rate <= `SCM_UART_RATE_RST;
		air_rate_select <= `SCM_AIR_RATE_RST; // see RULE7
		out2_function <= `SCM_OUT2_RST;
		out1_function <= `SCM_OUT1_RST;
		number_format <= `SCM_FORMAT_RST;
		source_address <= 16'hFFFF;
		reply_valid <= 1'b0;
		reply_byte <= 8'h00;
		reply_hex <= 1'b1;
		reply_units <= 1'b0;
		reply_value <= 19'h0_0000;
		reply_second <= 1'b0;
		reply_low <= 8'h00;
		cmd_error <= 1'b0;
	end else begin
		data_valid <= 1'b0;
		reply_valid <= 1'b0;
		cmd_error <= 1'b0;
		if (rx_valid) begin
			silence <= 16'h0000;
		end else if (tick && silence != 16'hFFFF) begin
			silence <= silence + 16'h0001;
		end
		case (state)
			ST_IDLE: begin
				if (rx_valid) begin
					// escape only counts after the full leading silence
					if (rx_data == escape_char_code && silence >= guard_before_time) begin
						state <= ST_ESC; // see RULE1
						esc_count <= 2'h1;
						held_low <= rx_data;
						held_count <= 2'h1;
					end else begin
						data_valid <= 1'b1;
						data_byte <= rx_data;
					end
				end
			end
			ST_ESC: begin
				if (rx_valid) begin
					if (rx_data == escape_char_code) begin
						esc_count <= esc_count + 2'h1;
						held_count <= held_count + 2'h1;
						if (esc_count + 2'h1 == `SCM_ESCAPE_COUNT) begin
							state <= ST_AFTER;
						end
					end else begin
						// abort: held escapes flushed, this char kept as data
						state <= ST_IDLE; // see RULE19
						data_valid <= 1'b1;
						data_byte <= rx_data;
						held_count <= 2'h0;
					end
				end
			end
			ST_AFTER: begin
				if (rx_valid) begin
					state <= ST_IDLE; // see RULE19
					data_valid <= 1'b1;
					data_byte <= rx_data;
					held_count <= 2'h0;
				end else if (silence >= guard_after_time) begin
					state <= ST_CMD; // see RULE1
					command_mode <= 1'b1;
					held_count <= 2'h0;
				end
			end
			ST_CMD: begin
				if (cmd_valid) begin
					// numeric values arrive as binary words, read as hex
					case (cmd_code) // see RULE12
						`SCM_CMD_LEAVE: begin
							state <= ST_IDLE; // see RULE13
							command_mode <= 1'b0;
							active_uart_rate <= next_rate; // see RULE6
						end
						`SCM_CMD_GUARD_BEFORE: begin // see RULE17
							if (cmd_write) begin
								guard_before_time <= cmd_value; // see RULE2
							end
							reply_value <= {3'h0, guard_before_time};
							reply_second <= 1'b1; // see RULE18
						end
						`SCM_CMD_GUARD_AFTER: begin
							if (cmd_write && cmd_value >= `SCM_GUARD_AFTER_MIN &&
								cmd_value <= after_limit) begin
								guard_after_time <= cmd_value; // see RULE3
							end else if (cmd_write) begin
								cmd_error <= 1'b1;
							end
							reply_value <= {3'h0, guard_after_time};
							reply_second <= 1'b1;
						end
						`SCM_CMD_ESCAPE: begin
							if (cmd_write && cmd_value[15:8] == 8'h00 &&
								cmd_value[7:0] >= `SCM_ESCAPE_MIN &&
								cmd_value[7:0] <= `SCM_ESCAPE_MAX) begin
								escape_char_code <= cmd_value[7:0]; // see RULE4
							end else if (cmd_write) begin
								cmd_error <= 1'b1;
							end
							reply_value <= {11'h000, escape_char_code};
							reply_second <= 1'b0;
						end
						`SCM_CMD_UART_RATE: begin
							if (cmd_write && cmd_value <= {12'h000, `SCM_UART_RATE_MAX}) begin
								uart_rate_select <= cmd_value[3:0]; // see RULE6
							end else if (cmd_write) begin
								cmd_error <= 1'b1;
							end
							reply_value <= {15'h0000, uart_rate_select};
							reply_second <= 1'b0; // see RULE18
						end
						`SCM_CMD_AIR_RATE: begin
							if (cmd_write && cmd_value <= 16'h0001) begin
								air_rate_select <= cmd_value[0]; // see RULE7
							end else if (cmd_write) begin
								cmd_error <= 1'b1;
							end
							reply_value <= {18'h0_0000, air_rate_select};
							reply_second <= 1'b0;
						end
						`SCM_CMD_OUT2: begin
							if (cmd_write && cmd_value <= {14'h0000, `SCM_OUT2_MAX}) begin
								out2_function <= cmd_value[1:0]; // see RULE8
							end else if (cmd_write) begin
								cmd_error <= 1'b1;
							end
							reply_value <= {17'h0_0000, out2_function};
							reply_second <= 1'b0;
						end
						`SCM_CMD_OUT1: begin
							if (cmd_write && cmd_value <= {13'h0000, `SCM_OUT1_MAX}) begin
								out1_function <= cmd_value[2:0]; // see RULE9
							end else if (cmd_write) begin
								cmd_error <= 1'b1;
							end
							reply_value <= {16'h0000, out1_function};
							reply_second <= 1'b0;
						end
						`SCM_CMD_FORMAT: begin
							if (cmd_write && cmd_value <= {14'h0000, `SCM_FORMAT_MAX}) begin
								number_format <= cmd_value[1:0]; // see RULE10
							end else if (cmd_write) begin
								cmd_error <= 1'b1;
							end
							reply_value <= {17'h0_0000, number_format};
							reply_second <= 1'b0;
						end
						`SCM_CMD_AUTO_ADDR: begin
							source_address <= auto_addr; // see RULE14
							reply_value <= {3'h0, auto_addr};
							reply_second <= 1'b1;
						end
						`SCM_CMD_VOLTAGE: begin
							reply_value <= board_voltage; // see RULE15
							reply_second <= 1'b1;
						end
						`SCM_CMD_LAST_RSSI: begin
							reply_value <= {12'h000, last_packet_rssi}; // see RULE16
							reply_second <= 1'b0;
						end
						`SCM_CMD_FW_VERSION: begin
							reply_value <= {3'h0, firmware_version};
							reply_second <= 1'b1;
						end
						`SCM_CMD_HW_VERSION: begin
							reply_value <= {3'h0, hardware_version};
							reply_second <= 1'b1;
						end
						default: begin
							cmd_error <= 1'b1;
						end
					endcase
					if (cmd_code != `SCM_CMD_LEAVE) begin
						state <= ST_REPLY;
					end
					// versions are hex regardless of format
					reply_hex <= (cmd_code == `SCM_CMD_FW_VERSION ||
						cmd_code == `SCM_CMD_HW_VERSION ||
						number_format == `SCM_FMT_HEX); // see RULE11
					reply_units <= (number_format == `SCM_FMT_NATIVE_UNITS) &&
						(cmd_code == `SCM_CMD_LAST_RSSI ||
						cmd_code == `SCM_CMD_VOLTAGE); // see RULE16
				end
			end
			ST_REPLY: begin
				// two-byte replies go high byte first
				reply_valid <= 1'b1;
				if (reply_second) begin
					reply_byte <= reply_value[15:8];
					reply_low <= reply_value[7:0];
					reply_second <= 1'b0;
					state <= ST_REPLY;
					held_count <= 2'h1;
				end else begin
					reply_byte <= (held_count != 2'h0) ? reply_low : reply_value[7:0];
					held_count <= 2'h0;
					state <= ST_CMD;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
		endcase
	end
end

// ----------------------------------------
// general outputs
// ----------------------------------------
always @(posedge clock or negedge arst_n) begin
	if (!arst_n) begin
		general_out_two <= 1'b0;
		general_out_one <= 1'b0;
	end else begin
		case (out2_function) // see RULE8
			`SCM_OUT2_RX_LED: general_out_two <= rx_led;
			`SCM_OUT2_HIGH: general_out_two <= 1'b1;
			default: general_out_two <= 1'b0;
		endcase
		case (out1_function) // see RULE9
			`SCM_OUT1_CTS: general_out_one <= cts_level;
			`SCM_OUT1_TXEN_LOW: general_out_one <= ~tx_active;
			`SCM_OUT1_HIGH: general_out_one <= 1'b1;
			`SCM_OUT1_TXEN_HIGH: general_out_one <= tx_active;
			default: general_out_one <= 1'b0;
		endcase
	end
end

endmodule // scm_command_mode

// ---- verification/scm_command_mode_props.sv ----
// Purpose: concurrent checks on the command-mode block ports
// Assumes: one clock, asynchronous active-low reset
// Notes: reads requests as taken only while no reply is leaving
`timescale 1ns/1ns
module scm_command_mode_props #(
	parameter [31:0] UNIT_CYCLES = 32'h0000_000A
) (
	// clock and reset
	input wire clock,
	input wire arst_n,
	// stimulus side
	input wire rx_valid,
	input wire [7:0] rx_data,
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	input wire cmd_write,
	input wire [15:0] cmd_value,
	input wire [31:0] serial_number,
	// block outputs
	input wire command_mode,
	input wire data_valid,
	input wire [7:0] data_byte,
	input wire [3:0] active_uart_rate,
	input wire [17:0] uart_bps,
	input wire [1:0] number_format,
	input wire [15:0] source_address,
	input wire reply_valid,
	input wire reply_hex,
	input wire reply_units
);
default clocking @(posedge clock); endclocking
default disable iff (!arst_n);
// ----
// quiet-line counter
// ----
reg [31:0] quiet;
always @(posedge clock or negedge arst_n) begin
	if (!arst_n)
		quiet <= 32'h0000_0000;
	else if (rx_valid)
		quiet <= 32'h0000_0000;
	else if (quiet != 32'hFFFF_FFFF)
		quiet <= quiet + 32'h0000_0001;
end
function automatic [17:0] bps_of(input [3:0] c);
	case (c)
		4'h0: bps_of = 18'd1200;
		4'h1: bps_of = 18'd2400;
		4'h2: bps_of = 18'd4800;
		4'h3: bps_of = 18'd9600;
		4'h4: bps_of = 18'd19200;
		4'h5: bps_of = 18'd38400;
		4'h6: bps_of = 18'd57600;
		4'h7: bps_of = 18'd115200;
		default: bps_of = 18'd230400;
	endcase
endfunction
// ----
// sequences and properties
// ----
sequence s_req(logic [7:0] c, logic w);
	command_mode && cmd_valid && !reply_valid && cmd_code == c && cmd_write == w;
endsequence
sequence s_two;
	##2 reply_valid ##1 reply_valid ##1 !reply_valid;
endsequence
sequence s_one;
	##2 reply_valid ##1 !reply_valid;
endsequence
property p_leave; s_req(8'h09, 1'b0) |=> !command_mode; endproperty
property p_rate_hold;
	!(command_mode && cmd_valid && cmd_code == 8'h09) |=> $stable(active_uart_rate);
endproperty
property p_bps; uart_bps == bps_of(active_uart_rate); endproperty
property p_guard_two; s_req(8'h04, 1'b0) |-> s_two; endproperty
property p_rate_one; s_req(8'h15, 1'b0) |-> s_one; endproperty
property p_auto;
	s_req(8'h40, 1'b0) |-> ##[1:3]
		source_address == {serial_number[29], serial_number[28], serial_number[13:0]};
endproperty
property p_fw_hex; s_req(8'h14, 1'b0) |-> ##2 reply_valid && reply_hex; endproperty
property p_rssi;
	s_req(8'h36, 1'b0) |-> ##2 reply_valid && reply_hex == (number_format == 2'h1)
		&& reply_units == (number_format == 2'h0);
endproperty
property p_pass;
	!command_mode && rx_valid && rx_data < 8'h20 |=> data_valid && data_byte == $past(rx_data);
endproperty
property p_enter; $rose(command_mode) |-> quiet >= UNIT_CYCLES; endproperty
property p_fmt;
	s_req(8'h1F, 1'b1) ##0 (cmd_value < 16'h0003) |-> ##[1:2] number_format == cmd_value[1:0];
endproperty
a_leave: assert property (p_leave) else $error("leave code did not exit");
a_rate_hold: assert property (p_rate_hold) else $error("rate moved early");
a_bps: assert property (p_bps) else $error("bit rate decode wrong");
a_guard_two: assert property (p_guard_two) else $error("guard read not two bytes");
a_rate_one: assert property (p_rate_one) else $error("rate read not one byte");
a_auto: assert property (p_auto) else $error("auto address wrong");
a_fw_hex: assert property (p_fw_hex) else $error("version not hex");
a_rssi: assert property (p_rssi) else $error("strength format wrong");
a_pass: assert property (p_pass) else $error("data not passed");
a_enter: assert property (p_enter) else $error("entry without quiet");
a_fmt: assert property (p_fmt) else $error("format not stored");
endmodule // scm_command_mode_props

// ---- verification/scm_host.sv ----
// Purpose: host model sending characters into the block
// Assumes: one character per strobe on the block clock
// Notes: the line shows a moving pattern between characters
`timescale 1ns/1ns
module scm_host (
	// clock
	input wire clock,
	// characters toward the block
	output reg rx_valid,
	output wire [7:0] rx_data
);
reg [7:0] held;
reg [7:0] idle;
initial begin
	rx_valid = 1'b0;
	held = 8'h00;
	idle = 8'h00;
end
// a stale character must not look valid between strobes
always @(posedge clock) idle <= idle + 8'h35;
assign rx_data = rx_valid ? held : idle;
// caller keeps the silences around the escapes
task automatic send(input [7:0] ch);
	@(posedge clock);
	rx_valid <= 1'b1;
	held <= ch;
	@(posedge clock);
	rx_valid <= 1'b0;
endtask
endmodule // scm_host

// ---- verification/serial_command_mode_config_test.sv ----
// Purpose: self-checking bench for the command-mode block
// Assumes: 10 clocks stand for one 100 ms unit
// Notes: replies and passed data are compared with queues
`timescale 1ns/1ns
module serial_command_mode_config_test;
localparam [31:0] UNIT = 32'h0000_000A;
reg clock = 0;
reg arst_n = 0;
reg cmd_valid = 0;
reg cmd_write = 0;
reg [7:0] cmd_code = 0;
reg [15:0] cmd_value = 0;
reg [15:0] sleep_t = 16'hFFFF;
reg [15:0] fw = 0;
reg [31:0] serial = 0;
reg [18:0] volts = 0;
reg [6:0] rssi = 0;
reg cts = 0;
reg txa = 0;
reg rxa = 0;
reg hx, un, err_seen;
reg [18:0] val;
reg [7:0] esc = 8'h2B;
wire rx_valid, cmode, dv, air, out1, out2, rv, rhex, runits, cerr;
wire [7:0] rx_data, db, rb;
wire [3:0] rate;
wire [17:0] bps;
wire [1:0] fmt;
wire [15:0] src;
reg [15:0] gv;
wire [18:0] rval;
integer n_errors = 0;
integer check_count = 0;
integer cyc = 0;
integer k;
int unsigned bt[9] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200, 230400};
logic [7:0] dq[$], eq[$], rq[$], xq[$];
initial forever #2 clock = ~clock;
scm_host host (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data));
scm_command_mode #(.UNIT_CYCLES(UNIT)) dut (.clock(clock), .arst_n(arst_n),
	.rx_valid(rx_valid), .rx_data(rx_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
	.cmd_write(cmd_write), .cmd_value(cmd_value), .serial_number(serial),
	.sleep_inactivity_time(sleep_t), .board_voltage(volts), .last_packet_rssi(rssi),
	.firmware_version(fw), .hardware_version(~fw), .cts_level(cts), .tx_active(txa),
	.rx_activity_pin(rxa), .command_mode(cmode), .data_valid(dv), .data_byte(db),
	.active_uart_rate(rate), .uart_bps(bps), .air_rate_select(air), .number_format(fmt),
	.source_address(src), .general_out_one(out1), .general_out_two(out2), .reply_valid(rv),
	.reply_byte(rb), .reply_hex(rhex), .reply_units(runits), .reply_value(rval),
	.cmd_error(cerr));
// ----
// monitors and helpers
// ----
always @(posedge clock) begin
	cyc <= cyc + 1;
	if (dv === 1'b1) dq.push_back(db);
	if (rv === 1'b1) begin
		rq.push_back(rb);
		hx = rhex;
		un = runits;
		val = rval;
	end
	if (cerr === 1'b1) err_seen = 1;
end
// ceiling well above the ~3200 cycles the sequence needs
always @(posedge clock) if (cyc == 12000) begin
	n_errors = n_errors + 1;
	results();
end
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
	check_count = check_count + 1;
	if (g !== e) begin
		n_errors = n_errors + 1;
		$display("ERROR %s expected %0h seen %0h", nm, e, g);
	end
endtask
task automatic qchk(input string nm, ref logic [7:0] x[$], ref logic [7:0] s[$]);
	chk({nm, " count"}, x.size(), s.size());
	foreach (x[j]) if (j < s.size()) chk(nm, x[j], s[j]);
	x.delete();
	s.delete();
endtask
task automatic cmd(input [7:0] c, input w, input [15:0] v);
	rq.delete();
	err_seen = 0;
	@(posedge clock);
	cmd_valid <= 1'b1;
	cmd_code <= c;
	cmd_write <= w;
	cmd_value <= v;
	@(posedge clock);
	cmd_valid <= 1'b0;
	repeat (5) @(posedge clock);
endtask
task automatic wr(input [7:0] c, input [15:0] v, input e);
	cmd(c, 1'b1, v);
	chk("cmd error", e, err_seen);
endtask
task automatic rd(input [7:0] c, input integer n, input [15:0] v);
	cmd(c, 1'b0, 16'h0000);
	if (n == 2) xq.push_back(v[15:8]);
	xq.push_back(v[7:0]);
	qchk("reply", xq, rq);
endtask
task automatic enter(input [7:0] e);
	integer i;
	repeat (130) @(posedge clock);
	repeat (3) host.send(e);
	repeat (80) @(posedge clock);
	chk("early entry", 0, cmode);
	for (i = 0; i < 60 && cmode !== 1'b1; i++) @(posedge clock);
	chk("entered", 1, cmode);
endtask
task automatic results();
	$display("checks %0d errors %0d", check_count, n_errors);
	if (n_errors == 0 && check_count > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
endtask
// ----
// main sequence
// ----
initial begin
	void'($urandom(25));
	serial = $urandom;
	fw = $urandom;
	repeat (2) @(posedge clock);
	arst_n <= 1'b1;
	@(posedge clock);
	chk("rate", 3, rate);
	chk("bps", 9600, bps);
	chk("air", 1, air);
	chk("format", 1, fmt);
	chk("out2", 0, out2);
	host.send(8'h0D);
	host.send(8'h2B);
	repeat (130) @(posedge clock);
	host.send(8'h2B);
	host.send(8'h2B);
	host.send(8'h0D);
	repeat (130) @(posedge clock);
	repeat (3) host.send(8'h2B);
	repeat (20) @(posedge clock);
	host.send(8'h0D);
	repeat (120) @(posedge clock);
	chk("aborted", 0, cmode);
	eq = '{8'h0D, 8'h2B, 8'h0D, 8'h0D};
	qchk("data", eq, dq);
	enter(esc);
	rd(8'h04, 2, 16'h000A);
	rd(8'h05, 2, 16'h000A);
	rd(8'h13, 1, 16'h002B);
	rd(8'h15, 1, 16'h0003);
	gv = $urandom;
	wr(8'h04, gv, 1'b0);
	rd(8'h04, 2, gv);
	wr(8'h04, 16'h000A, 1'b0);
	wr(8'h05, 16'h0001, 1'b1);
	wr(8'h05, 16'h7FFD, 1'b1);
	wr(8'h05, 16'h7FFC, 1'b0);
	rd(8'h05, 2, 16'h7FFC);
	sleep_t <= 16'h0010;
	wr(8'h05, 16'h000E, 1'b1);
	wr(8'h05, 16'h000A, 1'b0);
	wr(8'h13, 16'h001F, 1'b1);
	esc = 8'h20 + ($urandom % 32'h0000_0060);
	wr(8'h13, {8'h00, esc}, 1'b0);
	rd(8'h13, 1, {8'h00, esc});
	for (k = 0; k < 9; k++) begin
		wr(8'h15, k[15:0], 1'b0);
		chk("rate held", k == 0 ? 3 : k - 1, rate);
		cmd(8'h09, 1'b0, 16'h0000);
		chk("left", 0, cmode);
		chk("rate", k, rate);
		chk("bps", bt[k], bps);
		enter(esc);
	end
	wr(8'h39, 16'h0000, 1'b0);
	chk("air", 0, air);
	chk("rate", 8, rate);
	wr(8'h28, 16'h0001, 1'b0);
	chk("out2", 1, out2);
	wr(8'h28, 16'h0000, 1'b0);
	chk("out2", 0, out2);
	rxa <= 1'b1;
	repeat (5) @(posedge clock);
	chk("out2", 1, out2);
	for (k = 0; k < 5; k++) begin
		txa <= $urandom;
		cts <= $urandom;
		wr(8'h2C, k[15:0], 1'b0);
		chk("out1", (k == 0 && cts) || k == 2 || (k == 1 && !txa) ||
			(k == 3 && txa), out1);
	end
	for (k = 0; k < 3; k++) begin
		rssi <= 7'h28 + ($urandom % 32'h0000_0047);
		wr(8'h1F, k[15:0], 1'b0);
		chk("format", k, fmt);
		rd(8'h36, 1, {9'h000, rssi});
		chk("hex", k == 1, hx);
		chk("units", k == 0, un);
		rd(8'h14, 2, fw);
		chk("hex", 1, hx);
		rd(8'h16, 2, ~fw);
		chk("hex", 1, hx);
	end
	wr(8'h1F, 16'h0003, 1'b1);
	wr(8'h1F, 16'h0001, 1'b0);
	volts <= 19'h2_CCCA + ($urandom % 32'h0002_F331);
	cmd(8'h3B, 1'b0, 16'h0000);
	chk("volts", volts, val);
	chk("hex", 1, hx);
	rd(8'h40, 2, {serial[29], serial[28], serial[13:0]});
	chk("address", {serial[29], serial[28], serial[13:0]}, src);
	cmd(8'h09, 1'b0, 16'h0000);
	chk("left", 0, cmode);
	cmd(8'h04, 1'b0, 16'h0000);
	qchk("ignored", xq, rq);
	arst_n <= 1'b0;
	@(posedge clock);
	arst_n <= 1'b1;
	@(posedge clock);
	chk("rate", 3, rate);
	results();
end
endmodule // serial_command_mode_config_test
bind scm_command_mode scm_command_mode_props #(.UNIT_CYCLES(UNIT_CYCLES)) u_props (
	.clock(clock), .arst_n(arst_n), .rx_valid(rx_valid), .rx_data(rx_data),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write),
	.cmd_value(cmd_value), .serial_number(serial_number), .command_mode(command_mode),
	.data_valid(data_valid), .data_byte(data_byte), .active_uart_rate(active_uart_rate),
	.uart_bps(uart_bps), .number_format(number_format), .source_address(source_address),
	.reply_valid(reply_valid), .reply_hex(reply_hex), .reply_units(reply_units));
